// [include/sas_cfg.svh]
// register map, field positions, reset values and timing counts of the converter sequencer
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH

// register indices; the byte address is four times the index
`define SAS_IDX_CTRL_ONE        8'h1C
`define SAS_IDX_TIMING          8'h1D
`define SAS_IDX_STATUS_LOW      8'h1E
`define SAS_IDX_RESULT_UPPER    8'h1F

// control one fields
`define SAS_CTRL_TRIG_BIT       7
`define SAS_CTRL_MODE_HI        6
`define SAS_CTRL_MODE_LO        5
`define SAS_CTRL_GATE_BIT       4
`define SAS_CTRL_CHAN_HI        3
`define SAS_CTRL_CHAN_LO        0

// timing control fields
`define SAS_TIM_LADDER_BIT      5
`define SAS_TIM_FIXED1_BIT      4
`define SAS_TIM_SEL_HI          3
`define SAS_TIM_SEL_LO          1
`define SAS_TIM_FIXED0_BIT      0

// status fields
`define SAS_ST_RES_HI           7
`define SAS_ST_RES_LO           6
`define SAS_ST_DONE_BIT         5
`define SAS_ST_BUSY_BIT         4

// reset values
`define SAS_CTRL_RESET          8'h00
`define SAS_TIMING_RESET        8'h00

// operating modes
`define SAS_MODE_OFF            2'h0
`define SAS_MODE_SOFT           2'h1
`define SAS_MODE_REPEAT         2'h3

// conversion time in main clock cycles per select code
`define SAS_CONV_CYC_0          11'd39
`define SAS_CONV_CYC_2          11'd78
`define SAS_CONV_CYC_3          11'd156
`define SAS_CONV_CYC_4          11'd312
`define SAS_CONV_CYC_5          11'd624
`define SAS_CONV_CYC_6          11'd1248

`endif

// [include/sas_pkg.sv]
// types shared by the converter sequencer files
package sas_pkg;

    // sequencer states, one-hot
    typedef enum logic [1:0] {
        SAS_IDLE = 2'b01,
        SAS_CONV = 2'b10
    } sas_state_t;

    // avalon-mm request from the master
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } sas_avm_req_t;

    // lines to the analog converter core
    typedef struct packed {
        logic       sampleStart;
        logic       convActive;
        logic [3:0] channel;
        logic       inputGateOff;
        logic       ladderOn;
    } sas_analog_t;

    // counter state
    typedef struct packed {
        logic [10:0] count;
        logic        running;
        logic        done;
    } sas_cnt_state_t;

    // sequencer state
    typedef struct packed {
        sas_state_t  fsm;
        logic        trig;
        logic [1:0]  mode;
        logic        gateOff;
        logic [3:0]  chan;
        logic        ladderSel;
        logic [2:0]  convSel;
        logic        fixedOne;
        logic        fixedZero;
        logic [7:0]  resUpper;
        logic [1:0]  resLow;
        logic        doneFlag;
        logic        busy;
        logic        irq;
        logic        start;
        logic        ack;
        logic [31:0] rdata;
    } sas_core_t;

endpackage

// [verilog/sas_cycle_counter.sv]
// down counter that times one conversion and pulses when it runs out
module sas_cycle_counter #(
    parameter int WIDTH = 11
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             abort,
    // status
    output logic                  done
);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [WIDTH-1:0] count;    // cycles left minus one
        logic             running;  // timing in progress
        logic             done;     // one-cycle expiry pulse
    } sas_cnt_t;

    sas_cnt_t cur_q;
    sas_cnt_t cur_d;

    ////////////////////////////////////////////////////////////////////////
    // next state: load beats abort so a repeat restart is never lost
    always_comb
    begin
        cur_d      = cur_q;
        cur_d.done = 1'b0;
        if (load)
        begin
            // n cycles from load to the done pulse
            cur_d.count   = loadValue - {{(WIDTH-1){1'b0}}, 1'b1};
            cur_d.running = 1'b1;
        end
        else if (abort)
        begin
            cur_d.running = 1'b0;
        end
        else if (cur_q.running)
        begin
            if (cur_q.count == '0)
            begin
                cur_d.running = 1'b0;
                cur_d.done    = 1'b1;
            end
            else
            begin
                cur_d.count = cur_q.count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // register
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            cur_q <= '0;
        else
            cur_q <= cur_d;
    end

    assign done = cur_q.done;

endmodule

// [verilog/sas_sequencer.sv]
// control and status sequencer of the 10-bit successive-approximation converter
//
// Operation
// RQ1: select code sets 39 to 1248 cycles
// RQ2: ladder connected during conversion or always
// RQ3: software writes bit0 zero, bit4 one
// RQ4: timing bits 7:6 read undefined
// RQ5: low power resets timing, blocks writes
// RQ6: software avoids inhibited conversion times
// RQ7: status holds result low, done, busy
// RQ8: upper result read clears done flag
// RQ9: busy follows conversion, clears in standby
// RQ10: software mode trigger starts one conversion
// RQ11: result, done flag, interrupt together
// RQ12: trigger clears itself once conversion starts
// RQ13: software waits for done before retrigger
// RQ14: repeat mode relaunches after each completion
// RQ15: mode off halts, drops partial result
// RQ16: restart clears done, keeps old result
// RQ17: software programs setup before trigger
// RQ18: upper eight and low two bits split
// RQ19: software changes channel only when idle
// RQ20: standby aborts, reinitialises, no resume
// RQ21: interrupt is one-cycle pulse with flag
//
// Decided for this implementation: the Avalon-MM slave port.
`include "sas_cfg.svh"

module sas_sequencer #(
    parameter int CNT_WIDTH = 11
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // avalon-mm slave
    input  sas_pkg::sas_avm_req_t     avmReq,
    output logic [31:0]               avmReaddata,
    output logic                      avmWaitrequest,
    // power state, high outside the normal operating modes
    input  wire logic                 lowPowerMode,
    // analog core
    input  wire logic [9:0]           sarResult,
    output sas_pkg::sas_analog_t      analogCtl,
    // interrupt
    output logic                      conversionDoneIrq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    sas_pkg::sas_core_t     cur_q;        // sequencer state except the timer in u_timer
    sas_pkg::sas_core_t     cur_d;        // its next value
    logic                   cntLoad;      // start timing a conversion
    logic                   cntAbort;     // drop the running timer
    logic                   cntDone;      // conversion time elapsed
    logic [CNT_WIDTH-1:0]   convCycles;   // decoded conversion time
    logic                   accTaken;     // bus access completes this edge
    logic [7:0]             regIdx;       // word index from byte address

    ////////////////////////////////////////////////////////////////////////
    // conversion time decode
    // RQ1 select code decode
    always_comb
    begin
        case (cur_q.convSel)
            3'h0:    convCycles = CNT_WIDTH'(`SAS_CONV_CYC_0);
            3'h2:    convCycles = CNT_WIDTH'(`SAS_CONV_CYC_2);
            3'h3:    convCycles = CNT_WIDTH'(`SAS_CONV_CYC_3);
            3'h4:    convCycles = CNT_WIDTH'(`SAS_CONV_CYC_4);
            3'h5:    convCycles = CNT_WIDTH'(`SAS_CONV_CYC_5);
            3'h6:    convCycles = CNT_WIDTH'(`SAS_CONV_CYC_6);
            // reserved codes fall back to the shortest time
            default: convCycles = CNT_WIDTH'(`SAS_CONV_CYC_0);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion timer
    sas_cycle_counter #(
        .WIDTH     (CNT_WIDTH)
    ) u_timer (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .load      (cntLoad),
        .loadValue (convCycles),
        .abort     (cntAbort),
        .done      (cntDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    // one wait state: the access completes on the second edge
    assign accTaken = (avmReq.read | avmReq.write) & cur_q.ack;
    assign regIdx   = {2'b00, avmReq.address[7:2]};

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        cur_d       = cur_q;
        cur_d.irq   = 1'b0;
        cur_d.start = 1'b0;
        cntLoad     = 1'b0;
        cntAbort    = 1'b0;

        // ack toggles so every request sees exactly one wait cycle
        cur_d.ack = (avmReq.read | avmReq.write) & ~cur_q.ack;

        // read data latched in the wait cycle, stable when waitrequest drops
        if (avmReq.read & ~cur_q.ack)
        begin
            case (regIdx)
                `SAS_IDX_CTRL_ONE:
                begin
                    cur_d.rdata = {24'h000000, cur_q.trig, cur_q.mode,
                                   cur_q.gateOff, cur_q.chan};
                end
                `SAS_IDX_TIMING:
                begin
                    // RQ4 upper two bits undefined
                    cur_d.rdata = {24'h000000, 2'b00, cur_q.ladderSel,
                                   cur_q.fixedOne, cur_q.convSel,
                                   cur_q.fixedZero};
                end
                `SAS_IDX_STATUS_LOW:
                begin
                    // RQ7 status layout, low nibble reads zero
                    cur_d.rdata = {24'h000000, cur_q.resLow, cur_q.doneFlag,
                                   cur_q.busy, 4'h0};
                end
                `SAS_IDX_RESULT_UPPER:
                begin
                    cur_d.rdata = {24'h000000, cur_q.resUpper};
                end
                // unmapped addresses read zero
                default:
                begin
                    cur_d.rdata = 32'h00000000;
                end
            endcase
        end

        // RQ8 upper result read clears flag
        if (accTaken & avmReq.read & (regIdx == `SAS_IDX_RESULT_UPPER))
        begin
            cur_d.doneFlag = 1'b0;
        end

        // register writes, blocked while in a low power state
        // RQ5 writes ignored in standby
        if (accTaken & avmReq.write & ~lowPowerMode)
        begin
            case (regIdx)
                `SAS_IDX_CTRL_ONE:
                begin
                    cur_d.mode    = avmReq.writedata[`SAS_CTRL_MODE_HI:`SAS_CTRL_MODE_LO];
                    cur_d.gateOff = avmReq.writedata[`SAS_CTRL_GATE_BIT];
                    cur_d.chan    = avmReq.writedata[`SAS_CTRL_CHAN_HI:`SAS_CTRL_CHAN_LO];
                    // a trigger only sticks in a mode that can convert
                    cur_d.trig    = avmReq.writedata[`SAS_CTRL_TRIG_BIT] &
                        ((cur_d.mode == `SAS_MODE_SOFT) |
                         (cur_d.mode == `SAS_MODE_REPEAT));
                end
                `SAS_IDX_TIMING:
                begin
                    cur_d.ladderSel = avmReq.writedata[`SAS_TIM_LADDER_BIT];
                    cur_d.fixedOne  = avmReq.writedata[`SAS_TIM_FIXED1_BIT];
                    cur_d.convSel   = avmReq.writedata[`SAS_TIM_SEL_HI:`SAS_TIM_SEL_LO];
                    cur_d.fixedZero = avmReq.writedata[`SAS_TIM_FIXED0_BIT];
                end
                // read-only and unmapped writes are dropped
                default:
                begin
                end
            endcase
        end

        // sequencer
        case (cur_q.fsm)
            sas_pkg::SAS_IDLE:
            begin
                // RQ10 software trigger starts conversion
                if (cur_q.trig & ((cur_q.mode == `SAS_MODE_SOFT) |
                                  (cur_q.mode == `SAS_MODE_REPEAT)))
                begin
                    cntLoad     = 1'b1;
                    cur_d.fsm   = sas_pkg::SAS_CONV;
                    cur_d.busy  = 1'b1;
                    cur_d.start = 1'b1;
                    // RQ12 trigger self clears
                    cur_d.trig  = 1'b0;
                    // RQ16 restart clears flag only
                    cur_d.doneFlag = 1'b0;
                end
            end
            sas_pkg::SAS_CONV:
            begin
                // RQ15 mode off halts at once
                if (cur_q.mode == `SAS_MODE_OFF)
                begin
                    cntAbort   = 1'b1;
                    cur_d.fsm  = sas_pkg::SAS_IDLE;
                    cur_d.busy = 1'b0;
                end
                else if (cntDone)
                begin
                    // RQ11 result, flag, interrupt together
                    // RQ18 split ten-bit result
                    cur_d.resUpper = sarResult[9:2];
                    cur_d.resLow   = sarResult[1:0];
                    // flag set wins over a same-cycle upper read
                    cur_d.doneFlag = 1'b1;
                    // RQ21 single-cycle interrupt pulse
                    cur_d.irq      = 1'b1;
                    // RQ14 repeat relaunches next conversion
                    if (cur_q.mode == `SAS_MODE_REPEAT)
                    begin
                        cntLoad     = 1'b1;
                        cur_d.start = 1'b1;
                    end
                    else
                    begin
                        // RQ9 busy drops at completion
                        cur_d.fsm  = sas_pkg::SAS_IDLE;
                        cur_d.busy = 1'b0;
                    end
                end
            end
            default:
            begin
                cur_d.fsm  = sas_pkg::SAS_IDLE;
                cur_d.busy = 1'b0;
            end
        endcase

        // low power overrides everything else except the bus handshake and read data
        // RQ20 standby aborts and reinitialises
        if (lowPowerMode)
        begin
            cntAbort        = 1'b1;
            cntLoad         = 1'b0;
            cur_d.fsm       = sas_pkg::SAS_IDLE;
            // RQ9 busy clears in standby
            cur_d.busy      = 1'b0;
            cur_d.start     = 1'b0;
            cur_d.irq       = 1'b0;
            cur_d.doneFlag  = 1'b0;
            cur_d.resUpper  = 8'h00;
            cur_d.resLow    = 2'b00;
            cur_d.trig      = 1'(`SAS_CTRL_RESET >> `SAS_CTRL_TRIG_BIT);
            cur_d.mode      = 2'(`SAS_CTRL_RESET >> `SAS_CTRL_MODE_LO);
            cur_d.gateOff   = 1'(`SAS_CTRL_RESET >> `SAS_CTRL_GATE_BIT);
            cur_d.chan      = 4'(`SAS_CTRL_RESET);
            // RQ5 timing register back to reset
            cur_d.ladderSel = 1'(`SAS_TIMING_RESET >> `SAS_TIM_LADDER_BIT);
            cur_d.fixedOne  = 1'(`SAS_TIMING_RESET >> `SAS_TIM_FIXED1_BIT);
            cur_d.convSel   = 3'(`SAS_TIMING_RESET >> `SAS_TIM_SEL_LO);
            cur_d.fixedZero = 1'(`SAS_TIMING_RESET);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cur_q           <= '0;
            cur_q.fsm       <= sas_pkg::SAS_IDLE;
            cur_q.trig      <= 1'(`SAS_CTRL_RESET >> `SAS_CTRL_TRIG_BIT);
            cur_q.mode      <= 2'(`SAS_CTRL_RESET >> `SAS_CTRL_MODE_LO);
            cur_q.gateOff   <= 1'(`SAS_CTRL_RESET >> `SAS_CTRL_GATE_BIT);
            cur_q.chan      <= 4'(`SAS_CTRL_RESET);
            cur_q.ladderSel <= 1'(`SAS_TIMING_RESET >> `SAS_TIM_LADDER_BIT);
            cur_q.fixedOne  <= 1'(`SAS_TIMING_RESET >> `SAS_TIM_FIXED1_BIT);
            cur_q.convSel   <= 3'(`SAS_TIMING_RESET >> `SAS_TIM_SEL_LO);
            cur_q.fixedZero <= 1'(`SAS_TIMING_RESET);
        end
        else
        begin
            cur_q <= cur_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign avmReaddata    = cur_q.rdata;
    // waitrequest is combinational so a new request stalls at once
    assign avmWaitrequest = (avmReq.read | avmReq.write) & ~cur_q.ack;

    // RQ21 interrupt straight from its flop
    assign conversionDoneIrq = cur_q.irq;

    // analog control lines
    assign analogCtl.sampleStart  = cur_q.start;
    assign analogCtl.convActive   = cur_q.busy;
    assign analogCtl.channel      = cur_q.chan;
    assign analogCtl.inputGateOff = cur_q.gateOff;
    // RQ2 ladder only while busy unless held on
    assign analogCtl.ladderOn     = cur_q.ladderSel | cur_q.busy;

endmodule

// [dv/sas_sequencer_asserts.sv]
// port-level assertions for the converter sequencer
module sas_sequencer_asserts (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            reset,
    // register bus
    input  sas_pkg::sas_avm_req_t avmReq,
    input  wire logic [31:0]     avmReaddata,
    input  wire logic            avmWaitrequest,
    // power and analog side
    input  wire logic            lowPowerMode,
    input  wire logic [9:0]      sarResult,
    input  sas_pkg::sas_analog_t  analogCtl,
    input  wire logic            conversionDoneIrq
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // cycles since the last start pulse, saturating so it never wraps
    logic [10:0] sinceStart_q;
    logic [10:0] sinceStart_d;

    // next count
    always_comb
    begin
        sinceStart_d = sinceStart_q;
        if (analogCtl.sampleStart)
            sinceStart_d = 11'h001;
        else if (sinceStart_q != 11'h7FF)
            sinceStart_d = sinceStart_q + 11'h001;
    end

    // count register
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            sinceStart_q <= 11'h000;
        else
            sinceStart_q <= sinceStart_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // completion lands exactly one table length plus the interrupt flop after start
    a_conv_length: assert property (conversionDoneIrq && !analogCtl.convActive |->
        sinceStart_q inside {11'd40, 11'd79, 11'd157, 11'd313, 11'd625, 11'd1249})
        else $error("conversion length off the table");
    a_irq_single: assert property (conversionDoneIrq |=> !conversionDoneIrq)
        else $error("interrupt longer than one cycle");
    a_irq_after_busy: assert property (conversionDoneIrq |-> $past(analogCtl.convActive))
        else $error("interrupt without a running conversion");
    a_start_busy: assert property (analogCtl.sampleStart |-> analogCtl.convActive)
        else $error("start without busy");
    a_start_pulse: assert property (analogCtl.sampleStart |=> !analogCtl.sampleStart[*8])
        else $error("start retriggered");
    a_ladder_busy: assert property (analogCtl.convActive |-> analogCtl.ladderOn)
        else $error("ladder off during conversion");
    a_lowpower_abort: assert property (lowPowerMode |=>
        !analogCtl.convActive && !conversionDoneIrq)
        else $error("conversion survived standby");
    a_mode_off_halt: assert property (avmReq.write && !avmWaitrequest &&
        avmReq.address == 8'h70 && avmReq.writedata[6:5] == 2'b00 |-> ##2 !analogCtl.convActive)
        else $error("mode off did not halt");
    a_status_bits: assert property (avmReq.read && !avmWaitrequest &&
        avmReq.address == 8'h78 |-> avmReaddata[31:8] == 24'h0 && avmReaddata[3:0] == 4'h0)
        else $error("status read has stray bits");
    a_timing_bits: assert property (avmReq.read && !avmWaitrequest &&
        avmReq.address == 8'h74 |-> avmReaddata[7:6] == 2'b00)
        else $error("timing read has stray bits");
endmodule

// [dv/sas_sequencer_bench.sv]
// self-checking bench for the converter sequencer
module sas_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // design signals
    logic                 ref_clk;
    logic                 reset;
    sas_pkg::sas_avm_req_t avmReq;
    logic [31:0]          avmReaddata;
    logic                 avmWaitrequest;
    logic                 lowPowerMode;
    logic [9:0]           sarResult;
    sas_pkg::sas_analog_t  analogCtl;
    logic                 conversionDoneIrq;
    // bench state
    int                   badCount;
    int                   numChecks;
    int                   cyc;
    logic [7:0]           rd;
    logic [9:0]           res;

    sas_sequencer dut_u (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .avmReq            (avmReq),
        .avmReaddata       (avmReaddata),
        .avmWaitrequest    (avmWaitrequest),
        .lowPowerMode      (lowPowerMode),
        .sarResult         (sarResult),
        .analogCtl         (analogCtl),
        .conversionDoneIrq (conversionDoneIrq)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // verdict and end of run
    task results;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one comparison
    task chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon access; held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avmReq <= '{address: a, read: !wr, write: wr, writedata: {24'h0, d}};
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (avmWaitrequest !== 1'b0 && n < 20);
        chk(n < 20, 1);
        // read data taken at the very edge the access completes
        rd = avmReaddata[7:0];
        avmReq <= '0;
    endtask

    // bounded wait for the done pulse, counting cycles from the trigger edge
    task waitIrq;
        cyc = 0;
        do
        begin
            @(negedge ref_clk);
            cyc++;
        end while (conversionDoneIrq !== 1'b1 && cyc < 1400);
        // back on a rising edge so following stimulus lands there
        @(posedge ref_clk);
    endtask

    // interrupt must stay quiet
    task quiet(input int n);
        repeat (n)
        begin
            @(negedge ref_clk);
            chk(conversionDoneIrq, 0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset values, read-only and unmapped places
    task tReset;
        bus(0, 8'h70, 8'h00); chk(rd, 8'h00);
        bus(0, 8'h74, 8'h00); chk(rd, 8'h00);
        bus(1, 8'h78, 8'hFF); bus(0, 8'h78, 8'h00); chk(rd, 8'h00);
        bus(0, 8'h00, 8'h00); chk(rd, 8'h00);
        bus(1, 8'h74, 8'hFE); bus(0, 8'h74, 8'h00); chk(rd, 8'h3E);
        @(negedge ref_clk); chk(analogCtl.ladderOn, 1);
        bus(1, 8'h74, 8'h10);
        @(negedge ref_clk); chk(analogCtl.ladderOn, 0);
        bus(1, 8'h70, 8'h10);
        @(negedge ref_clk); chk(analogCtl.inputGateOff, 1);
    endtask

    // every time code in software mode, result split and flag clear
    task tCodes;
        logic [2:0] code [6];
        int         len [6];
        code = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
        len = '{39, 78, 156, 312, 624, 1248};
        for (int i = 0; i < 6; i++)
        begin
            res = 10'h2C5 + 10'(i * 97);
            sarResult <= res;
            bus(1, 8'h70, 8'h23);
            bus(1, 8'h74, {4'h1, code[i], 1'b0});
            bus(1, 8'h70, 8'hA3);
            waitIrq(); chk(cyc, len[i] + 3);
            chk(analogCtl.channel, 4'h3);
            bus(0, 8'h78, 8'h00); chk(rd, {res[1:0], 6'h20});
            bus(0, 8'h7C, 8'h00); chk(rd, res[9:2]);
            bus(0, 8'h78, 8'h00); chk(rd, {res[1:0], 6'h00});
        end
    endtask

    // restart before reading keeps the old result
    task tRestart;
        bus(1, 8'h74, 8'h10);
        sarResult <= 10'h155;
        bus(1, 8'h70, 8'hA3);
        waitIrq();
        sarResult <= 10'h2AA;
        bus(1, 8'h70, 8'hA3);
        bus(0, 8'h70, 8'h00); chk(rd, 8'h23);
        bus(0, 8'h78, 8'h00); chk(rd, 8'h50);
        bus(0, 8'h7C, 8'h00); chk(rd, 8'h55);
        waitIrq(); chk(cyc < 1400, 1);
        bus(0, 8'h78, 8'h00); chk(rd, 8'hA0);
        bus(0, 8'h7C, 8'h00); chk(rd, 8'hAA);
    endtask

    // repeat mode relaunches, mode off drops the partial result
    task tRepeat;
        sarResult <= 10'h0F3;
        bus(1, 8'h70, 8'h65);
        bus(1, 8'h70, 8'hE5);
        waitIrq();
        waitIrq(); chk(cyc < 1400, 1);
        chk(analogCtl.channel, 4'h5);
        sarResult <= 10'h3FF;
        bus(1, 8'h70, 8'h05);
        quiet(100);
        chk(analogCtl.convActive, 0);
        bus(0, 8'h78, 8'h00); chk(rd, 8'hE0);
        bus(0, 8'h7C, 8'h00); chk(rd, 8'h3C);
    endtask

    // standby in mid conversion aborts and reinitialises
    task tStandby;
        bus(1, 8'h70, 8'h21);
        bus(1, 8'h74, 8'h30);
        sarResult <= 10'h111;
        bus(1, 8'h70, 8'hA1);
        repeat (5) @(posedge ref_clk);
        lowPowerMode <= 1'b1;
        bus(1, 8'h74, 8'h3A);
        @(negedge ref_clk); chk(analogCtl.convActive, 0);
        chk(analogCtl.ladderOn, 0);
        @(posedge ref_clk);
        lowPowerMode <= 1'b0;
        quiet(60);
        bus(0, 8'h74, 8'h00); chk(rd, 8'h00);
        bus(0, 8'h70, 8'h00); chk(rd, 8'h00);
        bus(0, 8'h7C, 8'h00); chk(rd, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        avmReq = '0;
        lowPowerMode = 1'b0;
        sarResult = 10'h000;
        reset = 1'b1;
        badCount = 0;
        numChecks = 0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        tReset();
        tCodes();
        tRestart();
        tRepeat();
        tStandby();
        results();
    end

    // watchdog, well beyond the roughly three thousand cycles the run needs
    initial
    begin
        #200000;
        $display("unexpected at %0t: timeout got %h expected %h", $time, 1'b1, 1'b0);
        badCount++;
        results();
    end
endmodule

bind sas_sequencer sas_sequencer_asserts chk_u (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .avmReq            (avmReq),
    .avmReaddata       (avmReaddata),
    .avmWaitrequest    (avmWaitrequest),
    .lowPowerMode      (lowPowerMode),
    .sarResult         (sarResult),
    .analogCtl         (analogCtl),
    .conversionDoneIrq (conversionDoneIrq)
);
